// ==== logic/spg_pkg.sv ====
// Package for the sleep and peripheral clock gating block.
// Assumes an APB slave with 32-bit data, one word per register.
package spg_pkg;
    localparam logic [11:0] SPG_SLEEP_CTRL_ADDR = 12'h000;
    localparam logic [11:0] SPG_CLK_GATE_ADDR = 12'h004;
    localparam logic [11:0] SPG_STATUS_ADDR = 12'h008;
    localparam logic [7:0] SPG_SLEEP_CTRL_RST = 8'h00;
    localparam logic [7:0] SPG_CLK_GATE_RST = 8'h00;
    localparam logic [7:0] SPG_SLEEP_CTRL_MASK = 8'h0F;
    localparam logic [7:0] SPG_CLK_GATE_MASK = 8'hEF;
    localparam int SPG_ENABLE_POS = 0;
    localparam int SPG_MODE_LSB = 1;
    localparam int SPG_GATE_CONV = 0;
    localparam int SPG_GATE_SERIAL_PORT = 1;
    localparam int SPG_GATE_SERIAL_PERIPH = 2;
    localparam int SPG_GATE_TIMER_ONE = 3;
    localparam int SPG_GATE_TIMER_ZERO = 5;
    localparam int SPG_GATE_TIMER_TWO = 6;
    localparam int SPG_GATE_TWO_WIRE = 7;
    localparam int SPG_CLK_HZ = 20000000;
    localparam int SPG_WAKE_HALT_CYCLES = 4;
    localparam logic [2:0] SPG_WAKE_HALT_CNT = 3'(SPG_WAKE_HALT_CYCLES);

    typedef enum logic [2:0] {
        SPG_MODE_IDLE = 3'h0,
        SPG_MODE_NOISE_RED = 3'h1,
        SPG_MODE_POWER_DOWN = 3'h2,
        SPG_MODE_POWER_SAVE = 3'h3,
        SPG_MODE_STANDBY = 3'h6
    } spg_mode_t;

    typedef enum {
        SPG_ST_RUN,
        SPG_ST_SLEEP,
        SPG_ST_WAKE
    } spg_state_t;
endpackage : spg_pkg

// ==== logic/spg_top.sv ====
// Sleep control and per-peripheral clock gating with an APB slave.
// Assumes the core pulses sleep_instr_i and waits for wake-up to finish.
//
// Notes on behaviour
// R1 - Mode field bits 3..1: 000 idle,001 noise,010 down,011 save,110 stby
// R2 - Sleep instruction enters sleep only when enable bit 0 is one
// R3 - Software sets enable just before sleep, clears it after waking
// R4 - Sleep control bits 7..4 read as zero
// R5 - Gate bit 7 stops the two-wire unit clock
// R6 - Gate bit 6 stops timer two only when it runs synchronously
// R7 - Gate bit 5 stops timer zero; clearing resumes its frozen state
// R8 - Gate bit 4 is reserved and reads as zero
// R9 - Gate bit 3 stops timer one; clearing resumes its frozen state
// R10 - Gate bit 2 stops the SPI clock
// R11 - Gate bit 1 stops the USART clock
// R12 - Gate bit 0 shuts the ADC; comparator loses ADC input mux
// R13 - Software disables the ADC before setting its gate bit
// R14 - Software re-initialises two-wire, SPI or USART after ungating
// R15 - Software leaves SPI gate clear while single-wire debug is used
// R16 - Enabled ADC stays enabled in sleep; re-enable asks extended conversion
// R17 - Comparator off in deep sleep unless it uses internal reference
// R18 - Reference on when brown-out, comparator or ADC needs it
// R19 - Brown-out and watchdog stay enabled in every sleep mode
// R20 - Input buffers off when I/O and ADC clocks both stop, except wake
// R21 - Debug enabled keeps main clock source running in every sleep
// R22 - Gated peripheral frozen, its registers inaccessible
// R23 - Core halted four cycles beyond start-up after wake interrupt
// R24 - Both registers reset to zero
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spg_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sleep_instr_i,
    input wire logic wake_irq_i,
    input wire logic startup_done_i,
    input wire logic timer_two_async_select_i,
    input wire logic adc_enable_i,
    input wire logic comp_enable_i,
    input wire logic comp_use_ref_i,
    input wire logic debug_enable_setting_i,
    input wire logic brownout_level_enabled_i,
    input wire logic watchdog_enable_i,
    output logic [7:0] clk_gate_o,
    output logic periph_access_block_o,
    output logic comp_mux_block_o,
    output logic core_halt_o,
    output logic sleeping_o,
    output logic irq_vector_go_o,
    output logic [2:0] clk_group_run_o,
    output logic main_osc_run_o,
    output logic adc_run_o,
    output logic adc_extended_conv_o,
    output logic comp_run_o,
    output logic ref_on_o,
    output logic brownout_run_o,
    output logic watchdog_run_o,
    output logic input_buf_en_o,
    output logic wake_buf_only_o
);
    import spg_pkg::*;

    // Decoded mode (reserved codes behave as idle)
    function automatic logic [3:0] spg_decode(input logic [2:0] m);
        // {io_clk_stopped, adc_clk_stopped, osc_stopped, reserved}
        case (m)
            SPG_MODE_IDLE: spg_decode = 4'h0;
            SPG_MODE_NOISE_RED: spg_decode = 4'h8;
            SPG_MODE_POWER_DOWN: spg_decode = 4'hE;
            SPG_MODE_POWER_SAVE: spg_decode = 4'hC;
            SPG_MODE_STANDBY: spg_decode = 4'hC;
            default: spg_decode = 4'h1;
        endcase
    endfunction : spg_decode

    logic [7:0] sleep_ctrl_q, sleep_ctrl_d;
    logic [7:0] clk_gate_q, clk_gate_d;
    logic [2:0] act_mode_q, act_mode_d;
    spg_state_t state_q, state_d;
    logic [2:0] halt_cnt_q, halt_cnt_d;
    logic adc_en_prev_q, adc_en_prev_d;
    logic ext_conv_q, ext_conv_d;
    logic [31:0] prdata_q, prdata_d;
    logic wr_acc, rd_acc, addr_ok;
    logic [3:0] mode_info;
    logic asleep;

    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && !penable_i && !pwrite_i;
    assign addr_ok = (paddr_i == SPG_SLEEP_CTRL_ADDR)
        || (paddr_i == SPG_CLK_GATE_ADDR) || (paddr_i == SPG_STATUS_ADDR);

    // Registers and read data
    always_comb begin
        sleep_ctrl_d = sleep_ctrl_q;
        clk_gate_d = clk_gate_q;
        prdata_d = prdata_q;
        if (wr_acc && pstrb_i[0]) begin
            if (paddr_i == SPG_SLEEP_CTRL_ADDR) begin
                sleep_ctrl_d = pwdata_i[7:0] & SPG_SLEEP_CTRL_MASK; // see R4
            end
            if (paddr_i == SPG_CLK_GATE_ADDR) begin
                clk_gate_d = pwdata_i[7:0] & SPG_CLK_GATE_MASK; // see R8
            end
        end
        if (rd_acc) begin
            case (paddr_i)
                SPG_SLEEP_CTRL_ADDR: prdata_d = {24'h000000, sleep_ctrl_q};
                SPG_CLK_GATE_ADDR: prdata_d = {24'h000000, clk_gate_q};
                SPG_STATUS_ADDR: prdata_d = {26'h0000000, ext_conv_q,
                    state_q == SPG_ST_SLEEP, act_mode_q, 1'b0};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_ctrl_q <= SPG_SLEEP_CTRL_RST; // see R24
            clk_gate_q <= SPG_CLK_GATE_RST; // see R24
            prdata_q <= 32'h00000000;
        end else begin
            sleep_ctrl_q <= sleep_ctrl_d;
            clk_gate_q <= clk_gate_d;
            prdata_q <= prdata_d;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign prdata_o = prdata_q;

    // Sleep sequencer
    always_comb begin
        state_d = state_q;
        act_mode_d = act_mode_q;
        halt_cnt_d = halt_cnt_q;
        case (state_q)
            SPG_ST_RUN: begin
                if (sleep_instr_i && sleep_ctrl_q[SPG_ENABLE_POS]) begin // see R2
                    state_d = SPG_ST_SLEEP;
                    act_mode_d = sleep_ctrl_q[SPG_MODE_LSB +: 3]; // see R1
                end
            end
            SPG_ST_SLEEP: begin
                if (wake_irq_i) begin
                    state_d = SPG_ST_WAKE;
                    halt_cnt_d = SPG_WAKE_HALT_CNT;
                end
            end
            SPG_ST_WAKE: begin
                // Counting starts only once the oscillator is stable
                if (startup_done_i) begin
                    if (halt_cnt_q == 3'h1) begin
                        state_d = SPG_ST_RUN; // see R23
                        halt_cnt_d = 3'h0;
                    end else begin
                        halt_cnt_d = halt_cnt_q - 3'h1;
                    end
                end
            end
            default: state_d = SPG_ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SPG_ST_RUN;
            act_mode_q <= 3'h0;
            halt_cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            act_mode_q <= act_mode_d;
            halt_cnt_q <= halt_cnt_d;
        end
    end

    assign asleep = (state_q == SPG_ST_SLEEP);
    assign mode_info = asleep ? spg_decode(act_mode_q) : 4'h0;
    assign sleeping_o = asleep;
    assign core_halt_o = (state_q != SPG_ST_RUN) || sleep_instr_i
        && sleep_ctrl_q[SPG_ENABLE_POS];
    assign irq_vector_go_o = (state_q == SPG_ST_WAKE) && startup_done_i
        && (halt_cnt_q == 3'h1); // see R23
    // {io, adc, osc} clock groups running
    assign clk_group_run_o = ~mode_info[3:1];

    // ADC off/on edge tracking for the extended conversion request
    always_comb begin
        adc_en_prev_d = adc_enable_i;
        ext_conv_d = ext_conv_q;
        if (adc_enable_i && !adc_en_prev_q) begin
            ext_conv_d = 1'b1; // see R16
        end else if (!adc_enable_i) begin
            ext_conv_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_en_prev_q <= 1'b0;
            ext_conv_q <= 1'b0;
        end else begin
            adc_en_prev_q <= adc_en_prev_d;
            ext_conv_q <= ext_conv_d;
        end
    end
    assign adc_extended_conv_o = ext_conv_q;

    // Per-peripheral gates; timer two gate ignored in async mode
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gate
            if (gi == SPG_GATE_TIMER_TWO) begin : g_t2
                assign clk_gate_o[gi] = clk_gate_q[gi]
                    && !timer_two_async_select_i; // see R6
            end else begin : g_std
                // Bits 7,5,3,2,1,0; bit 4 is held zero
                assign clk_gate_o[gi] = clk_gate_q[gi]; // see R5
            end
        end
    endgenerate
    // see R7, R9, R10, R11: gating only stops clocks, so state is kept
    // see R22: access to a gated unit is blocked
    assign periph_access_block_o = |clk_gate_o;
    assign comp_mux_block_o = clk_gate_q[SPG_GATE_CONV]; // see R12

    assign adc_run_o = adc_enable_i && !clk_gate_q[SPG_GATE_CONV]; // see R16
    assign comp_run_o = comp_enable_i && (!mode_info[2]
        || comp_use_ref_i); // see R17
    assign ref_on_o = brownout_level_enabled_i || adc_run_o
        || (comp_run_o && comp_use_ref_i); // see R18
    assign brownout_run_o = brownout_level_enabled_i; // see R19
    assign watchdog_run_o = watchdog_enable_i; // see R19
    assign main_osc_run_o = !mode_info[1] || debug_enable_setting_i; // see R21
    assign input_buf_en_o = !(mode_info[3] && mode_info[2]); // see R20
    assign wake_buf_only_o = mode_info[3] && mode_info[2]; // see R20

    chk_sleep_gated: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (state_q == SPG_ST_RUN && sleep_instr_i
        && !sleep_ctrl_q[SPG_ENABLE_POS]) |=> state_q == SPG_ST_RUN) // see R2
        else $error("sleep entered with enable clear");
    chk_mode_latched: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (state_q == SPG_ST_RUN && sleep_instr_i
        && sleep_ctrl_q[SPG_ENABLE_POS]) |=> (sleeping_o
        && act_mode_q == $past(sleep_ctrl_q[3:1]))) // see R1
        else $error("sleep mode not taken from selector");
    chk_wake_halt: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (state_q == SPG_ST_WAKE && startup_done_i && halt_cnt_q == 3'h4)
        ##1 (core_halt_o && startup_done_i)[*3]
        |-> irq_vector_go_o ##1 state_q == SPG_ST_RUN) // see R23
        else $error("wake halt not four cycles");
    chk_ctrl_upper: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        sleep_ctrl_q[7:4] == 4'h0) // see R4
        else $error("sleep control upper bits set");
    chk_gate_resv: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        !clk_gate_q[4] && !clk_gate_o[4]) // see R8
        else $error("reserved gate bit set");
    chk_t2_async: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        timer_two_async_select_i |-> !clk_gate_o[SPG_GATE_TIMER_TWO]) // see R6
        else $error("timer two gated in async mode");
    chk_comp_deep: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (sleeping_o && act_mode_q == 3'h2 && !comp_use_ref_i)
        |-> !comp_run_o) // see R17
        else $error("comparator running in power-down");
    chk_gate_write: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (wr_acc && pstrb_i[0] && paddr_i == SPG_CLK_GATE_ADDR)
        |=> clk_gate_o[SPG_GATE_TWO_WIRE] == $past(pwdata_i[7])) // see R5
        else $error("two-wire gate not following write");
    chk_osc_debug: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        debug_enable_setting_i |-> main_osc_run_o) // see R21
        else $error("main clock stopped with debug enabled");
endmodule : spg_top
`default_nettype wire

// ==== testbench/spg_core_model.sv ====
// Core model: retires sleep instructions and wakes the block by interrupt.
// Assumes the block's sleeping and halt outputs follow the handover timing.
`timescale 1ns/1ps
`default_nettype none
module spg_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sleep_req_i,
    input wire logic sleeping_i,
    input wire logic core_halt_i,
    output logic sleep_instr_o,
    output logic wake_irq_o,
    output logic startup_done_o
);
    logic [1:0] nap_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nap_q <= 2'h0;
            sleep_instr_o <= 1'b0;
            wake_irq_o <= 1'b0;
            startup_done_o <= 1'b0;
        end else begin
            sleep_instr_o <= sleep_req_i;
            nap_q <= sleeping_i ? nap_q + 2'h1 : 2'h0;
            // Held until the core runs, as a pending interrupt would be
            wake_irq_o <= (sleeping_i && nap_q == 2'h3) ||
                          (wake_irq_o && core_halt_i);
            startup_done_o <= wake_irq_o && !sleeping_i;
        end
    end
endmodule : spg_core_model
`default_nettype wire

// ==== testbench/spg_top_bench.sv ====
// Self-checking bench for the sleep and clock gating block.
// Assumes the core model drives sleep and wake; APB is driven here.
`timescale 1ns/1ps
`default_nettype none
module spg_top_bench;
    import spg_pkg::*;
    logic core_clk_i, rst_n, psel, penable, pwrite, sleep_req, t2_async;
    logic adc_en, comp_en, dbg_en, bod_en, wdt_en, sleep_instr, wake_irq;
    logic startup_done, pready_o, pslverr_o, core_halt_o, sleeping_o;
    logic irq_vector_go_o, periph_access_block_o, comp_mux_block_o;
    logic main_osc_run_o, adc_run_o, comp_run_o, ref_on_o, input_buf_en_o;
    logic brownout_run_o, watchdog_run_o, e, comp_ref, ext_conv, wbuf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_o, r;
    logic [7:0] clk_gate_o;
    logic [2:0] clk_group_run_o, m, g;
    logic [2:0] grp_exp [8] = '{3'h7, 3'h3, 3'h0, 3'h1, 3'h7, 3'h7, 3'h1, 3'h7};
    int failures = 0, cmp_count = 0, halt_n = 0, vec_n = 0, h0, v0;
    spg_top u_spg_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sleep_instr_i(sleep_instr), .wake_irq_i(wake_irq),
        .startup_done_i(startup_done), .timer_two_async_select_i(t2_async),
        .adc_enable_i(adc_en), .comp_enable_i(comp_en),
        .comp_use_ref_i(comp_ref), .debug_enable_setting_i(dbg_en),
        .brownout_level_enabled_i(bod_en), .watchdog_enable_i(wdt_en),
        .clk_gate_o(clk_gate_o), .periph_access_block_o(periph_access_block_o),
        .comp_mux_block_o(comp_mux_block_o), .core_halt_o(core_halt_o),
        .sleeping_o(sleeping_o), .irq_vector_go_o(irq_vector_go_o),
        .clk_group_run_o(clk_group_run_o), .main_osc_run_o(main_osc_run_o),
        .adc_run_o(adc_run_o), .adc_extended_conv_o(ext_conv),
        .comp_run_o(comp_run_o),
        .ref_on_o(ref_on_o), .brownout_run_o(brownout_run_o),
        .watchdog_run_o(watchdog_run_o), .input_buf_en_o(input_buf_en_o),
        .wake_buf_only_o(wbuf));
    spg_core_model u_spg_core_model (.clk_i(core_clk_i), .rst_n_i(rst_n),
        .sleep_req_i(sleep_req), .sleeping_i(sleeping_o),
        .core_halt_i(core_halt_o), .sleep_instr_o(sleep_instr),
        .wake_irq_o(wake_irq), .startup_done_o(startup_done));
    always #25 core_clk_i = ~core_clk_i;
    // Halt cycles after start-up, and vector pulses, for the wake check
    // Sampled mid-cycle so the count never races the design's own edge
    always @(negedge core_clk_i) begin
        if (core_halt_o && startup_done && !sleeping_o) halt_n <= halt_n + 1;
        if (irq_vector_go_o) vec_n <= vec_n + 1;
    end
    task stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task check(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            stop_test();
        end
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        check("read_data", r, x);
        check("read_error", e, xe);
    endtask : rd
    task wait_state(input logic want);
        int n;
        n = 0;
        do begin
            // Falling edge: outputs have settled before they are looked at
            @(negedge core_clk_i);
            n++;
        end while (!(sleeping_o === want && (want || core_halt_o === 1'b0))
                   && n < 60);
        if (n >= 60) begin
            failures++;
            stop_test();
        end
    endtask : wait_state
    task pulse();
        @(posedge core_clk_i);
        sleep_req <= 1'b1;
        @(posedge core_clk_i);
        sleep_req <= 1'b0;
    endtask : pulse
    initial begin
        core_clk_i = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, sleep_req, t2_async, adc_en} = 6'h0;
        {comp_en, dbg_en, bod_en, wdt_en, comp_ref} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge core_clk_i);
        rst_n <= 1'b1;
        rd(SPG_SLEEP_CTRL_ADDR, 32'h0, 1'b0);
        rd(SPG_CLK_GATE_ADDR, 32'h0, 1'b0);
        apb(1'b1, SPG_SLEEP_CTRL_ADDR, 32'hFF);
        rd(SPG_SLEEP_CTRL_ADDR, 32'h0F, 1'b0);
        apb(1'b1, SPG_CLK_GATE_ADDR, 32'hFF);
        rd(SPG_CLK_GATE_ADDR, 32'hEF, 1'b0);
        check("gates", clk_gate_o, 8'hEF);
        check("mux_block", comp_mux_block_o, 1'b1);
        check("access_block", periph_access_block_o, 1'b1);
        t2_async <= 1'b1;
        @(posedge core_clk_i);
        check("async_timer", clk_gate_o, 8'hAF);
        apb(1'b1, SPG_CLK_GATE_ADDR, 32'h0);
        @(posedge core_clk_i);
        check("access_free", periph_access_block_o, 1'b0);
        rd(12'h00C, 32'h0, 1'b1);
        apb(1'b1, SPG_SLEEP_CTRL_ADDR, {28'h0, 3'h2, 1'b0});
        pulse();
        repeat (3) @(posedge core_clk_i);
        check("no_sleep", sleeping_o, 1'b0);
        adc_en <= 1'b1;
        apb(1'b0, SPG_STATUS_ADDR, 32'h0);
        check("ext_conv", r[5], 1'b1);
        check("ext_conv_o", ext_conv, 1'b1);
        {bod_en, wdt_en, comp_en} <= 3'h7;
        for (int i = 0; i < 9; i++) begin
            m = (i == 8) ? 3'h2 : i[2:0];
            g = grp_exp[m];
            dbg_en <= (i == 8);
            // Enable set just before sleeping, cleared after waking
            apb(1'b1, SPG_SLEEP_CTRL_ADDR, {28'h0, m, 1'b1});
            h0 = halt_n;
            v0 = vec_n;
            pulse();
            wait_state(1'b1);
            if (i < 8) check("clk_groups", clk_group_run_o, g);
            check("main_osc", main_osc_run_o, g[0] | (i == 8));
            check("comp_run", comp_run_o, g[1]);
            check("input_buf", input_buf_en_o, g[2] | g[1]);
            check("wake_buf", wbuf, !(g[2] | g[1]));
            check("adc_ref", {adc_run_o, ref_on_o}, 2'h3);
            check("keep", {brownout_run_o, watchdog_run_o}, 2'h3);
            wait_state(1'b0);
            check("halt_cycles", 32'(halt_n - h0), 32'h4);
            check("vector", 32'(vec_n - v0), 32'h1);
            apb(1'b1, SPG_SLEEP_CTRL_ADDR, 32'h0);
        end
        // Comparator on the reference keeps running through power-down
        {adc_en, bod_en, comp_ref} <= 3'h1;
        apb(1'b1, SPG_SLEEP_CTRL_ADDR, {28'h0, 3'h2, 1'b1});
        pulse();
        wait_state(1'b1);
        check("comp_ref_run", comp_run_o, 1'b1);
        check("ref_comp", ref_on_o, 1'b1);
        check("ext_cleared", ext_conv, 1'b0);
        wait_state(1'b0);
        apb(1'b1, SPG_SLEEP_CTRL_ADDR, 32'h0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        failures++;
        stop_test();
    end
endmodule : spg_top_bench
`default_nettype wire
